// File: verilog/ee_spi_regs.svh
// Named constants of the serial EEPROM command and protection block.
// Assumes it is included by bare name from the package; the design uses its macros from there.
`ifndef EE_SPI_REGS_SVH
`define EE_SPI_REGS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define EE_SET_WRITE_LATCH_CMD 8'h06
`define EE_CLEAR_WRITE_LATCH_CMD 8'h04
`define EE_STATUS_READ_CMD 8'h05
`define EE_STATUS_WRITE_CMD 8'h01
`define EE_MEM_READ_CMD 8'h03
`define EE_MEM_WRITE_CMD 8'h02

// ----------------------------------------------------------------
// Status register bit positions and reset value
// ----------------------------------------------------------------
`define EE_SR_PIN_PROT 7
`define EE_SR_SEL_HI 3
`define EE_SR_SEL_LO 2
`define EE_SR_LATCH 1
`define EE_SR_BUSY 0
`define EE_SR_RESET 8'h00

// ----------------------------------------------------------------
// Array geometry and protected bases
// ----------------------------------------------------------------
`define EE_ADDR_W 12
`define EE_PAGE_W 5
`define EE_PAGE_BYTES 32
`define EE_MEM_BYTES 4096
`define EE_QUARTER_BASE 12'hC00
`define EE_HALF_BASE 12'h800

// ----------------------------------------------------------------
// Byte counts within a frame (saturating at data phase)
// ----------------------------------------------------------------
`define EE_NB_NONE 3'h0
`define EE_NB_OP 3'h1
`define EE_NB_SR 3'h2
`define EE_NB_ADDR 3'h3
`define EE_NB_DATA 3'h4
`define EE_LAST_BIT 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_TWC_NS 5000000
`define EE_MCLK_NS 10
`define EE_TIMER_W 20

`endif

// File: verilog/ee_pkg.sv
// Types shared by the serial EEPROM command and protection block.
// Assumes the constants header sits on the include path.
`include "ee_spi_regs.svh"
`default_nettype none

package ee_pkg;

  // System clock state: pin syncs, status bits, write timer
  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic cs_hi;
    logic wp1;
    logic wp2;
    logic wp3;
    logic wp_hi;
    logic write_latch_bit;
    logic [1:0] bp;
    logic pin_protect_enable;
    logic busy;
    logic [`EE_TIMER_W-1:0] timer;
  } ee_mstate_t;

  // Serial clock state: shifter, frame counters, page buffer
  typedef struct packed {
    logic [6:0] sh;
    logic [2:0] bitn;
    logic [2:0] nbytes;
    logic [7:0] op;
    logic [15:0] addr;
    logic [`EE_PAGE_W-1:0] ptr;
    logic [`EE_ADDR_W-1:0] rd_ptr;
    logic [`EE_PAGE_BYTES-1:0] vmask;
    logic [`EE_PAGE_BYTES-1:0][7:0] pbuf;
    logic bs1;
    logic bs2;
  } ee_sstate_t;

endpackage : ee_pkg

`default_nettype wire

// File: verilog/ee_spi_protect.sv
// Command decode, protection and page write of a 32-Kbit SPI EEPROM.
// Assumes a host drives sck, cs_n, si and hold_n (SPI mode 0 or 3),
// and a free-running mclk at 100 MHz with synchronous rst.
`timescale 1ns/1ps
`default_nettype none

module ee_spi_protect #(
  // Write cycle length in mclk cycles (longest time, rounded down)
  parameter int WRITE_CYCLES = `EE_TWC_NS / `EE_MCLK_NS
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial link from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  // Hardware protect pin
  input wire logic wp_n,
  // Serial output, three-state: enable low while driving
  output logic so_out,
  output logic so_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ee_pkg::ee_mstate_t m_reg; // System clock state
  ee_pkg::ee_mstate_t m_next; // Its next value
  ee_pkg::ee_sstate_t sk_reg; // Serial clock state
  ee_pkg::ee_sstate_t sk_next; // Its next value
  ee_pkg::ee_sstate_t sk_base; // Cleared at frame start
  logic fresh_reg; // Frame not yet clocked
  logic [7:0] mem [0:`EE_MEM_BYTES-1]; // Array storage
  logic [7:0] byte_in; // Byte completing at this edge
  logic [7:0] tx_byte; // Byte being shifted out
  logic [7:0] sr_in; // Value carried by a status write
  logic drive; // Output should be driven
  logic cs_rise; // Agreed select rise, one cycle
  logic commit; // Select rise while not busy
  logic v_set_write_latch_cmd; // Well-formed latch set frame
  logic v_clear_write_latch_cmd; // Well-formed latch clear frame
  logic v_status_write_cmd; // Status write allowed
  logic v_write; // Memory write allowed
  logic pin_lock; // Pin protection active
  logic byte_edge; // Frame ended on a byte boundary

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // Block protection decode of an array address
  function automatic logic in_prot(
    input logic [1:0] sel,
    input logic [`EE_ADDR_W-1:0] a
  );
    case (sel)
      2'h0: in_prot = 1'b0; // Nothing protected
      2'h1: in_prot = (a >= `EE_QUARTER_BASE); // Top quarter
      2'h2: in_prot = (a >= `EE_HALF_BASE); // Top half
      default: in_prot = 1'b1; // Whole array
    endcase
  endfunction : in_prot

  // Assemble the status byte, unused bits zero
  function automatic logic [7:0] sr_byte(
    input ee_pkg::ee_mstate_t m
  );
    sr_byte = `EE_SR_RESET;
    sr_byte[`EE_SR_PIN_PROT] = m.pin_protect_enable;
    sr_byte[`EE_SR_SEL_HI] = m.bp[1];
    sr_byte[`EE_SR_SEL_LO] = m.bp[0];
    sr_byte[`EE_SR_LATCH] = m.write_latch_bit;
    sr_byte[`EE_SR_BUSY] = m.busy;
  endfunction : sr_byte

  // ----------------------------------------------------------------
  // Serial clock domain: frame start marker
  // ----------------------------------------------------------------
  // Set while select is high, cleared by the first rising edge
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      fresh_reg <= 1'b1;
    end
    else
    begin
      fresh_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial clock domain: input shifter and frame decode
  // ----------------------------------------------------------------
  // Counters restart at each frame; fields stay put after select
  // rises so the system clock side can read them while sck is idle
  always_comb
  begin
    sk_base = sk_reg;
    if (fresh_reg)
    begin
      sk_base = '0; // New frame: all counters and masks clear
    end
    sk_next = sk_base;
    byte_in = {sk_base.sh, si};
    if (hold_n) // Paused frames ignore si
    begin
      sk_next.sh = byte_in[6:0]; // Sample on rising edge
      sk_next.bitn = sk_base.bitn + 3'h1;
      sk_next.bs1 = m_reg.busy; // Busy level into this domain
      sk_next.bs2 = sk_base.bs1;
      if (sk_base.bitn == `EE_LAST_BIT)
      begin
        if (sk_base.nbytes != `EE_NB_DATA)
        begin
          sk_next.nbytes = sk_base.nbytes + 3'h1;
        end
        case (sk_base.nbytes)
          `EE_NB_NONE:
          begin
            sk_next.op = byte_in; // Instruction byte
          end
          `EE_NB_OP:
          begin
            sk_next.addr[15:8] = byte_in; // Or status value
          end
          `EE_NB_SR:
          begin
            sk_next.addr[7:0] = byte_in; // High nibble unused
            sk_next.ptr = byte_in[`EE_PAGE_W-1:0];
            sk_next.rd_ptr = {sk_base.addr[`EE_ADDR_W-1:8], byte_in};
          end
          default:
          begin
            if (sk_base.op == `EE_MEM_WRITE_CMD)
            begin
              // Load at pointer, wrap inside the page
              sk_next.pbuf[sk_base.ptr] = byte_in;
              sk_next.vmask[sk_base.ptr] = 1'b1;
              sk_next.ptr = sk_base.ptr + 5'h1;
            end
            if (sk_base.op == `EE_MEM_READ_CMD)
            begin
              // Next array byte, rolls over at top
              sk_next.rd_ptr = sk_base.rd_ptr + 12'h1;
            end
          end
        endcase
      end
    end
  end

  // Serial state register
  always_ff @(posedge sck)
  begin
    sk_reg <= sk_next;
  end

  // ----------------------------------------------------------------
  // Serial clock domain: output shifter
  // ----------------------------------------------------------------
  // Array contents are stable while read here: the array
  // only changes in a write cycle, and reads are refused then
  always_comb
  begin
    if (sk_reg.op == `EE_STATUS_READ_CMD)
    begin
      tx_byte = sr_byte(m_reg); // Full status, even when busy
    end
    else
    begin
      tx_byte = mem[sk_reg.rd_ptr];
    end
    // Only the two read commands ever drive
    drive = !fresh_reg && hold_n &&
      (((sk_reg.op == `EE_STATUS_READ_CMD) &&
        (sk_reg.nbytes >= `EE_NB_OP)) ||
       ((sk_reg.op == `EE_MEM_READ_CMD) &&
        (sk_reg.nbytes >= `EE_NB_ADDR) && !sk_reg.bs2));
  end

  // Shift out on falling edge; released at once when select rises
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_oe_n <= 1'b1; // Released while deselected
      so_out <= 1'b0;
    end
    else
    begin
      so_oe_n <= !drive; // Released during pause
      so_out <= tx_byte[~sk_reg.bitn]; // Falling edge
    end
  end

  // ----------------------------------------------------------------
  // System clock domain: commit decode
  // ----------------------------------------------------------------
  // Frame fields are read only after select has been high for
  // three mclk cycles, long after the last sck edge
  always_comb
  begin
    cs_rise = m_reg.cs2 && m_reg.cs3 && !m_reg.cs_hi;
    commit = cs_rise && !m_reg.busy; // Busy ignores all
    byte_edge = (sk_reg.bitn == 3'h0);
    sr_in = sk_reg.addr[15:8];
    pin_lock = m_reg.pin_protect_enable && !m_reg.wp_hi;
    // Latch set needs select high right after the opcode
    v_set_write_latch_cmd = (sk_reg.op == `EE_SET_WRITE_LATCH_CMD) && byte_edge &&
      (sk_reg.nbytes == `EE_NB_OP);
    v_clear_write_latch_cmd = (sk_reg.op == `EE_CLEAR_WRITE_LATCH_CMD) && byte_edge &&
      (sk_reg.nbytes == `EE_NB_OP);
    // Status write needs the latch and no pin lock
    v_status_write_cmd = (sk_reg.op == `EE_STATUS_WRITE_CMD) && byte_edge &&
      (sk_reg.nbytes == `EE_NB_SR) && m_reg.write_latch_bit && !pin_lock;
    // Memory write: latch, whole bytes, page outside protection
    v_write = (sk_reg.op == `EE_MEM_WRITE_CMD) && byte_edge &&
      (sk_reg.nbytes == `EE_NB_DATA) && m_reg.write_latch_bit &&
      !in_prot(m_reg.bp, {sk_reg.addr[`EE_ADDR_W-1:`EE_PAGE_W],
        5'h00});
  end

  // ----------------------------------------------------------------
  // System clock domain: status bits, pin syncs, write timer
  // ----------------------------------------------------------------
  always_comb
  begin
    m_next = m_reg;
    // Three-flop syncs; level taken once the last two agree
    m_next.cs1 = cs_n;
    m_next.cs2 = m_reg.cs1;
    m_next.cs3 = m_reg.cs2;
    m_next.wp1 = wp_n;
    m_next.wp2 = m_reg.wp1;
    m_next.wp3 = m_reg.wp2;
    if (m_reg.cs2 == m_reg.cs3)
    begin
      m_next.cs_hi = m_reg.cs2;
    end
    if (m_reg.wp2 == m_reg.wp3)
    begin
      m_next.wp_hi = m_reg.wp2;
    end
    // Write cycle countdown
    if (m_reg.busy)
    begin
      if (m_reg.timer == '0)
      begin
        m_next.busy = 1'b0; // Ready again
        m_next.write_latch_bit = 1'b0; // Back to write disabled
      end
      else
      begin
        m_next.timer = m_reg.timer - `EE_TIMER_W'(1);
      end
    end
    // Commands act only on the closing select rise
    if (commit)
    begin
      if (v_set_write_latch_cmd)
      begin
        m_next.write_latch_bit = 1'b1;
      end
      if (v_clear_write_latch_cmd)
      begin
        m_next.write_latch_bit = 1'b0;
      end
      if (v_status_write_cmd)
      begin
        // Only bits 7, 3 and 2 change
        m_next.pin_protect_enable = sr_in[`EE_SR_PIN_PROT];
        m_next.bp = {sr_in[`EE_SR_SEL_HI], sr_in[`EE_SR_SEL_LO]};
      end
      if (v_status_write_cmd || v_write)
      begin
        m_next.busy = 1'b1; // Self-timed cycle starts
        m_next.timer = `EE_TIMER_W'(WRITE_CYCLES - 1);
      end
    end
    // Synchronous reset stands in for power-up
    if (rst)
    begin
      m_next = '0; // Latch clear, not busy
      m_next.cs1 = 1'b1;
      m_next.cs2 = 1'b1;
      m_next.cs3 = 1'b1;
      m_next.cs_hi = 1'b1;
      m_next.wp1 = 1'b1;
      m_next.wp2 = 1'b1;
      m_next.wp3 = 1'b1;
      m_next.wp_hi = 1'b1;
    end
  end

  // System state register
  always_ff @(posedge mclk)
  begin
    m_reg <= m_next;
  end

  // ----------------------------------------------------------------
  // Array programming
  // ----------------------------------------------------------------
  // Loaded bytes of the page go in together at the commit
  always_ff @(posedge mclk)
  begin
    if (commit && v_write && !rst)
    begin
      for (int i = 0; i < `EE_PAGE_BYTES; i++)
      begin
        if (sk_reg.vmask[i])
        begin
          mem[{sk_reg.addr[`EE_ADDR_W-1:`EE_PAGE_W],
            i[`EE_PAGE_W-1:0]}] <= sk_reg.pbuf[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_set_write_latch_cmd_commit;
    commit && v_set_write_latch_cmd;
  endsequence

  sequence s_clear_write_latch_cmd_commit;
    commit && v_clear_write_latch_cmd;
  endsequence

  sequence s_write_commit;
    commit && (v_write || v_status_write_cmd);
  endsequence

  a_latch_set: assert property (
    @(posedge mclk) disable iff (rst)
    s_set_write_latch_cmd_commit |=> m_reg.write_latch_bit [*2])
    else $error("latch not set after set command");

  a_latch_clear: assert property (
    @(posedge mclk) disable iff (rst)
    s_clear_write_latch_cmd_commit |=> !m_reg.write_latch_bit)
    else $error("latch not cleared after clear command");

  a_busy_hold: assert property (
    @(posedge mclk) disable iff (rst)
    s_write_commit |=> m_reg.busy [*8])
    else $error("busy did not hold after write commit");

  a_busy_cause: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(m_reg.busy) |-> $past(commit))
    else $error("write cycle began without select rise");

  a_busy_end: assert property (
    @(posedge mclk) disable iff (rst)
    $fell(m_reg.busy) |-> !m_reg.write_latch_bit)
    else $error("latch still set after write cycle");

  a_pin_block: assert property (
    @(posedge mclk) disable iff (rst)
    commit && (sk_reg.op == `EE_STATUS_WRITE_CMD) && pin_lock
    |=> $stable(m_reg.bp) && $stable(m_reg.pin_protect_enable) && !m_reg.busy)
    else $error("status written while pin protected");

  a_busy_ignore: assert property (
    @(posedge mclk) disable iff (rst)
    cs_rise && m_reg.busy && (m_reg.timer != '0)
    |=> $stable(m_reg.bp) && $stable(m_reg.write_latch_bit) && m_reg.busy)
    else $error("command acted on during write cycle");

  a_no_latch: assert property (
    @(posedge mclk) disable iff (rst)
    commit && !m_reg.write_latch_bit |=> !m_reg.busy)
    else $error("write started with latch clear");

  a_sr_fields: assert property (
    @(posedge mclk) disable iff (rst)
    commit && v_status_write_cmd |=> (m_reg.pin_protect_enable == $past(sr_in[7])) &&
      (m_reg.bp == $past(sr_in[3:2])) && m_reg.write_latch_bit)
    else $error("status write stored wrong fields");

  a_reset_clear: assert property (
    @(posedge mclk)
    rst |=> !m_reg.write_latch_bit && !m_reg.busy)
    else $error("latch or busy set after reset");

  a_out_idle: assert property (
    @(posedge mclk) disable iff (rst)
    m_reg.cs_hi && m_reg.cs2 && m_reg.cs3 |-> so_oe_n)
    else $error("output driven while deselected");

endmodule : ee_spi_protect

`default_nettype wire

// File: tb/ee_host_model.sv
// Host model: SPI controller in mode 0 driving the EEPROM link.
// Assumes the bench calls xfer; sck stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module ee_host_model (
  // Link towards the device
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  output var logic hold_n,
  // Reply from the device
  input wire logic so_out,
  input wire logic so_oe_n
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // ----------------------------------------
  // One framed transfer, MSB first
  // ----------------------------------------
  // Reply bit taken at sck rise; undriven output reads as unknown
  task automatic xfer(input int nb, input logic [63:0] tx,
    output logic [63:0] rx, output logic oe_low);
    int i;
    rx = '0;
    oe_low = 1'b0;
    cs_n = 1'b0;
    #6;
    for (i = nb - 1; i >= 0; i--)
    begin
      si = tx[i];
      #6;
      sck = 1'b1;
      rx[i] = (so_oe_n === 1'b0) ? so_out : 1'bx;
      oe_low = oe_low | (so_oe_n === 1'b0);
      #6;
      sck = 1'b0;
    end
    #6;
    // Closing rise right after the last byte
    cs_n = 1'b1;
    // Released line must not keep the last bit
    si = ~si;
    #48;
  endtask : xfer
endmodule : ee_host_model

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the EEPROM command and protection block.
// Assumes ee_spi_protect and ee_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ----------------------------------------
  // Opcodes and probe tables
  // ----------------------------------------
  localparam logic [7:0] C_SET = 8'h06;
  localparam logic [7:0] C_CLR = 8'h04;
  localparam logic [7:0] C_SWR = 8'h01;
  localparam logic [7:0] C_SRD = 8'h05;
  localparam logic [7:0] C_MRD = 8'h03;
  localparam logic [7:0] C_MWR = 8'h02;
  localparam logic [7:0] BAD [4] = '{8'h00, 8'hFF, 8'h07, 8'h85};
  localparam logic [1:0] PB [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  localparam logic [11:0] PA [5] =
    '{12'hBFF, 12'hFFF, 12'h7FF, 12'hBFF, 12'h01E};
  localparam bit PACC [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  logic mclk, rst, wp_n, sck, cs_n, si, hold_n, so_out, so_oe_n;
  int n_fail, samples_checked;
  logic [7:0] exp_mem [0:4095]; // Expected array contents
  logic [63:0] rx;
  logic oel;

  // Clock of 10 ns
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  ee_spi_protect #(.WRITE_CYCLES(150)) dut (.mclk(mclk), .rst(rst),
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so_out(so_out), .so_oe_n(so_oe_n));

  ee_host_model host (.sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .so_out(so_out), .so_oe_n(so_oe_n));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task check(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Frame, then output must be released while deselected
  task frame(input int nb, input logic [63:0] tx);
    host.xfer(nb, tx, rx, oel);
    check("so_oe_n idle", {7'h00, so_oe_n}, 8'h01);
  endtask : frame

  task rd_status(input logic [7:0] exp);
    frame(16, {C_SRD, 8'h00});
    check("status", rx[7:0], exp);
  endtask : rd_status

  // Poll the busy flag under a bound
  task wait_ready;
    int k;
    for (k = 0; k < 50; k++)
    begin
      frame(16, {C_SRD, 8'h00});
      if (rx[0] === 1'b0)
        return;
    end
    n_fail++;
    $display("MISMATCH ready expected 0 seen 1");
    complete_run();
  endtask : wait_ready

  // Page load; model wraps slots inside the page
  task mem_wr(input logic [15:0] a, input int n, input logic [31:0] d,
    input bit acc);
    int k;
    frame(24 + 8 * n, (64'({C_MWR, a}) << (8 * n)) | 64'(d));
    for (k = 0; k < n; k++)
      if (acc)
        exp_mem[{a[11:5], a[4:0] + 5'(k)}] = d[8 * (n - 1 - k) +: 8];
  endtask : mem_wr

  task mem_chk(input logic [11:0] a, input int n);
    int k;
    frame(24 + 8 * n, 64'({C_MRD, 4'h0, a}) << (8 * n));
    for (k = 0; k < n; k++)
      check("mem", rx[8 * (n - 1 - k) +: 8], exp_mem[12'(a + k)]);
  endtask : mem_chk

  task set_status(input logic [7:0] v);
    frame(8, C_SET);
    frame(16, {C_SWR, v});
    wait_ready();
  endtask : set_status

  // Protect pin driven off the sampling edge, then synced
  task set_wp(input logic v);
    @(negedge mclk);
    wp_n = v;
    repeat (4) @(negedge mclk);
  endtask : set_wp

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_latch_cmds;
    rd_status(8'h00);
    frame(8, C_SET);
    rd_status(8'h02);
    frame(8, C_CLR);
    rd_status(8'h00);
    frame(16, {C_SET, 8'h00});
    rd_status(8'h00);
  endtask : t_latch_cmds

  task t_undefined;
    int i;
    for (i = 0; i < 4; i++)
    begin
      frame(16, {BAD[i], 8'h00});
      check("driven", {7'h00, oel}, 8'h00);
    end
    rd_status(8'h00);
  endtask : t_undefined

  task t_page_write;
    frame(8, C_SET);
    mem_wr(16'hF01E, 3, 32'hA1B2C3, 1'b1);
    rd_status(8'h03);
    frame(8, C_CLR);
    rd_status(8'h03);
    wait_ready();
    rd_status(8'h00);
    frame(8, C_SET);
    mem_wr(16'h0FFF, 2, 32'hD4E5, 1'b1);
    wait_ready();
    mem_chk(12'hFFF, 2);
    mem_chk(12'h01E, 2);
    mem_chk(12'hFE0, 1);
  endtask : t_page_write

  task t_block_protect;
    int i;
    // No latch: write refused
    mem_wr(16'h001E, 1, 32'h99, 1'b0);
    wait_ready();
    mem_chk(12'h01E, 1);
    for (i = 0; i < 5; i++)
    begin
      set_status({4'h0, PB[i], 2'b00});
      rd_status({4'h0, PB[i], 2'b00});
      frame(8, C_SET);
      mem_wr({4'h0, PA[i]}, 1, {24'h000000, 8'(16 + i)}, PACC[i]);
      wait_ready();
      mem_chk(PA[i], 1);
    end
  endtask : t_block_protect

  task t_pin_protect;
    set_status(8'hFF);
    rd_status(8'h8C);
    frame(16, {C_SWR, 8'h00});
    rd_status(8'h8C);
    set_wp(1'b0);
    frame(8, C_SET);
    frame(16, {C_SWR, 8'h00});
    wait_ready();
    rd_status(8'h8E);
    set_wp(1'b1);
    frame(16, {C_SWR, 8'h00});
    wait_ready();
    rd_status(8'h00);
  endtask : t_pin_protect

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    #500;
    t_latch_cmds();
    t_undefined();
    t_page_write();
    t_block_protect();
    t_pin_protect();
    complete_run();
  end

  initial
  begin
    #500000;
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    complete_run();
  end
endmodule : tb

`default_nettype wire
